// File: common/rps_pkg.sv
// constants and helpers shared by the remappable output pin select block
package rps_pkg;
  localparam int NPIN = 14;
  localparam int NPAIR = 7;
  localparam int SEL_W = 6;
  localparam int NFUNC = 64;
  localparam int FIRST_PIN = 12;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 3;
  // byte addresses of the seven output map registers
  localparam logic [11:0] OFS_MAP_12_13 = 12'h000;
  localparam logic [11:0] OFS_MAP_14_15 = 12'h004;
  localparam logic [11:0] OFS_MAP_16_17 = 12'h008;
  localparam logic [11:0] OFS_MAP_18_19 = 12'h00C;
  localparam logic [11:0] OFS_MAP_20_21 = 12'h010;
  localparam logic [11:0] OFS_MAP_22_23 = 12'h014;
  localparam logic [11:0] OFS_MAP_24_25 = 12'h018;
  // field layout inside one 16-bit map register
  localparam int EVEN_LSB = 0;
  localparam int EVEN_MSB = 5;
  localparam int ODD_LSB = 8;
  localparam int ODD_MSB = 13;
  localparam logic [15:0] MAP_RESET = 16'h0000;
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [5:0] FUNC_NONE = 6'h00;
  // pair index whose upper field is absent in the small package
  localparam logic [2:0] SMALL_PAIR = 3'h1;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  // decode a byte address into a register index, bit 3 flags a hit
  function automatic logic [3:0] map_decode(input logic [11:0] addr);
    logic [3:0] res;
    res = 4'h0;
    unique case (addr)
      OFS_MAP_12_13: res = 4'h8;
      OFS_MAP_14_15: res = 4'h9;
      OFS_MAP_16_17: res = 4'hA;
      OFS_MAP_18_19: res = 4'hB;
      OFS_MAP_20_21: res = 4'hC;
      OFS_MAP_22_23: res = 4'hD;
      OFS_MAP_24_25: res = 4'hE;
      default: res = 4'h0;
    endcase
    return res;
  endfunction
endpackage

// File: common/rps_reg_if.sv
// register access strobes between the bus slave and the map registers
`timescale 1ns/1ps
interface rps_reg_if;
  logic wr_lo;
  logic wr_hi;
  logic [2:0] idx;
  logic [15:0] wdata;
  logic [15:0] rd_data;
  modport slave(output wr_lo, output wr_hi, output idx, output wdata, input rd_data);
  modport regs(input wr_lo, input wr_hi, input idx, input wdata, output rd_data);
endinterface

// File: common/rps_sel_if.sv
// per-pin selector values from the map registers to the output mux
`timescale 1ns/1ps
interface rps_sel_if;
  logic [13:0][5:0] sel;
  modport src(output sel);
  modport dst(input sel);
endinterface

// File: design/rps_apb_slave.sv
// apb slave front end for the output map registers
`timescale 1ns/1ps
module rps_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rps_reg_if.slave rif
);
  logic [3:0] dec;
  logic hit;
  logic setup_rd;
  logic access;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // address decode and phase flags
  assign dec = rps_pkg::map_decode(paddr);
  assign hit = dec[3];
  assign setup_rd = psel & ~penable & ~pwrite;
  assign access = psel & penable;

  // zero wait states, error only on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // write strobes fire in the access phase, one for each of the two low byte lanes
  assign rif.idx = dec[2:0];
  assign rif.wdata = pwdata[15:0];
  assign rif.wr_lo = access & pwrite & hit & pstrb[0];
  assign rif.wr_hi = access & pwrite & hit & pstrb[1];

  // read data captured in setup so it stands through the access phase
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_rd) begin
      prdata_next = hit ? {16'h0000, rif.rd_data} : rps_pkg::RDATA_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
endmodule

// File: design/rps_out_mux.sv
// routes the selected peripheral output onto each remappable pin
`timescale 1ns/1ps
module rps_out_mux (
  input wire logic pclk,
  input wire logic presetn,
  rps_sel_if.dst sif,
  input wire logic [63:0] periph_out,
  output logic [13:0] remap_pin_out,
  output logic [13:0] remap_pin_active
);
  logic [13:0] out_reg;
  logic [13:0] out_next;
  logic [13:0] act_reg;
  logic [13:0] act_next;

  // one selector per pin, function zero leaves the pin unassigned
  genvar g;
  generate
    for (g = 0; g < rps_pkg::NPIN; g++) begin : g_pin
      assign act_next[g] = (sif.sel[g] != rps_pkg::FUNC_NONE);
      assign out_next[g] = act_next[g] ? periph_out[sif.sel[g]] : 1'b0;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 14'h0000;
      act_reg <= 14'h0000;
    end else begin
      out_reg <= out_next;
      act_reg <= act_next;
    end
  end

  assign remap_pin_out = out_reg;
  assign remap_pin_active = act_reg;
endmodule

// File: design/rps_top.sv
// top of the remappable output pin select block: map registers and checks
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - bits 15-14 and 7-6 of every map register are not stored, ignore writes and read zero.
// - bits 13-8 of each map register select the function of the odd pin of its pair.
// - bits 5-0 of each map register select the function of the even pin of its pair.
// - a pin whose selector holds a nonzero function n is driven by peripheral output n; function zero drives the pin low.
// - every implemented selector bit clears to zero at reset and is readable and writable, except the pin 15 selector in the small package.
// - in the small package the upper selector of the pins 14/15 register is absent, reads zero.
// - the seven registers cover pins 12 to 25 in ascending pairs, two pins per register.
module rps_top #(
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] periph_out,
  output logic [13:0] remap_pin_out,
  output logic [13:0] remap_pin_active,
  output logic [13:0][5:0] pin_output_select
);
  rps_reg_if rif ();
  rps_sel_if sif ();

  logic [13:0][5:0] sel_reg;
  logic [13:0][5:0] sel_next;

  // read word of one register from its two selectors
  function automatic logic [15:0] pack_pair(input logic [5:0] odd, input logic [5:0] even);
    return {2'b00, odd, 2'b00, even};
  endfunction

  // bus slave front end
  rps_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif)
  );

  // next selector values: register k holds pins 2k and 2k+1 of the window
  always_comb begin
    sel_next = sel_reg;
    for (int k = 0; k < rps_pkg::NPAIR; k++) begin
      if (rif.idx == k[2:0]) begin
        if (rif.wr_lo) begin
          sel_next[2*k] = rif.wdata[rps_pkg::EVEN_MSB:rps_pkg::EVEN_LSB];
        end
        if (rif.wr_hi) begin
          sel_next[2*k+1] = rif.wdata[rps_pkg::ODD_MSB:rps_pkg::ODD_LSB];
        end
      end
    end
    // upper field of pins 14/15 absent in the small package
    if (SMALL_PKG) begin
      sel_next[2*rps_pkg::SMALL_PAIR+1] = rps_pkg::SEL_RESET;
    end
  end

  // selector storage, cleared at power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= '0;
    end else begin
      sel_reg <= sel_next;
    end
  end

  // read-back mux over the addressed register
  always_comb begin
    rif.rd_data = rps_pkg::MAP_RESET;
    for (int k = 0; k < rps_pkg::NPAIR; k++) begin
      if (rif.idx == k[2:0]) begin
        rif.rd_data = pack_pair(sel_reg[2*k+1], sel_reg[2*k]);
      end
    end
  end

  // selectors travel to the mux, pin 15 gets its own field
  assign sif.sel = sel_reg;
  assign pin_output_select = sel_reg;

  // output routing toward the pad drivers
  rps_out_mux u_mux (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif),
    .periph_out(periph_out),
    .remap_pin_out(remap_pin_out),
    .remap_pin_active(remap_pin_active)
  );

  // helper state for the checks below
  logic [3:0] chk_dec;
  logic chk_hit;
  logic [2:0] chk_idx;
  logic last_wr_lo;
  logic last_wr_hi;
  logic [2:0] last_idx;
  logic [15:0] last_wdata;
  logic [13:0] exp_pin;
  logic [13:0] exp_act;

  assign chk_dec = rps_pkg::map_decode(paddr);
  assign chk_hit = chk_dec[3];
  assign chk_idx = chk_dec[2:0];

  // remember the last write for the field checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_wr_lo <= 1'b0;
      last_wr_hi <= 1'b0;
      last_idx <= 3'h0;
      last_wdata <= 16'h0000;
    end else begin
      last_wr_lo <= rif.wr_lo;
      last_wr_hi <= rif.wr_hi;
      last_idx <= rif.idx;
      last_wdata <= rif.wdata;
    end
  end

  // expected pin level from the current selectors
  always_comb begin
    for (int p = 0; p < rps_pkg::NPIN; p++) begin
      exp_pin[p] = (sel_reg[p] == rps_pkg::FUNC_NONE) ? 1'b0 : periph_out[sel_reg[p]];
      exp_act[p] = (sel_reg[p] != rps_pkg::FUNC_NONE);
    end
  end

  // apb phases used by the properties
  sequence s_rd_setup;
    psel && !penable && !pwrite && chk_hit;
  endsequence

  sequence s_rd_access;
    psel && penable && !pwrite;
  endsequence

  sequence s_wr_access;
    psel && penable && pwrite && chk_hit;
  endsequence

  property p_rsv_zero;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup ##1 s_rd_access |-> (prdata[15:14] == 2'b00) && (prdata[7:6] == 2'b00)
        && (prdata[31:16] == 16'h0000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read non-zero");

  property p_odd_field;
    @(posedge pclk) disable iff (!presetn)
      last_wr_hi && !(SMALL_PKG && last_idx == rps_pkg::SMALL_PAIR)
        |-> sel_reg[{last_idx, 1'b1}] == last_wdata[13:8];
  endproperty
  a_odd_field: assert property (p_odd_field) else $error("odd pin selector not written");

  property p_even_field;
    @(posedge pclk) disable iff (!presetn)
      last_wr_lo |-> sel_reg[{last_idx, 1'b0}] == last_wdata[5:0];
  endproperty
  a_even_field: assert property (p_even_field) else $error("even pin selector not written");

  property p_route;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> remap_pin_out == $past(exp_pin);
  endproperty
  a_route: assert property (p_route) else $error("pin not driven by selected output");

  property p_active;
    @(posedge pclk) disable iff (!presetn)
      (sel_reg[0] != rps_pkg::FUNC_NONE) ##1 (sel_reg[0] != rps_pkg::FUNC_NONE)
        |-> remap_pin_active[0];
  endproperty
  a_active: assert property (p_active) else $error("pin 12 not marked active");

  property p_reset_clear;
    @(posedge pclk) $rose(presetn) |-> (sel_reg == '0) && (remap_pin_out == 14'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("selectors not clear after reset");

  property p_readback;
    @(posedge pclk) disable iff (!presetn)
      s_rd_setup ##1 s_rd_access |-> prdata[13:8] == $past(sel_reg[{chk_idx, 1'b1}])
        && prdata[5:0] == $past(sel_reg[{chk_idx, 1'b0}]);
  endproperty
  a_readback: assert property (p_readback) else $error("read data differs from selectors");

  property p_small;
    @(posedge pclk) disable iff (!presetn)
      SMALL_PKG |-> sel_reg[2*rps_pkg::SMALL_PAIR+1] == rps_pkg::SEL_RESET;
  endproperty
  a_small: assert property (p_small) else $error("absent pin 15 selector holds a value");

  property p_pair_order;
    @(posedge pclk) disable iff (!presetn)
      (s_wr_access and (paddr == rps_pkg::OFS_MAP_24_25 && pstrb[0]))
        |=> sel_reg[12] == $past(pwdata[5:0]);
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("pins 24/25 register misplaced");

  property p_pin15;
    @(posedge pclk) disable iff (!presetn)
      (s_wr_access and (!SMALL_PKG && paddr == rps_pkg::OFS_MAP_14_15 && pstrb[1]))
        |=> sel_reg[3] == $past(pwdata[13:8]) ##1 remap_pin_active[3] == (sel_reg[3] != 6'h00);
  endproperty
  a_pin15: assert property (p_pin15) else $error("pin 15 not steered by its field");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !chk_hit |-> pslverr && pready && (sel_next == sel_reg);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  // a write with the low lane off keeps the even selector
  property p_even_hold;
    @(posedge pclk) disable iff (!presetn)
      (s_wr_access and !pstrb[0])
        |=> sel_reg[{$past(chk_idx), 1'b0}] == $past(sel_reg[{chk_idx, 1'b0}]);
  endproperty
  a_even_hold: assert property (p_even_hold) else $error("even selector disturbed");

  // a write with the high lane off keeps the odd selector
  property p_odd_hold;
    @(posedge pclk) disable iff (!presetn)
      (s_wr_access and !pstrb[1])
        |=> sel_reg[{$past(chk_idx), 1'b1}] == $past(sel_reg[{chk_idx, 1'b1}]);
  endproperty
  a_odd_hold: assert property (p_odd_hold) else $error("odd selector disturbed");

  property p_rd_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && !chk_hit) ##1 s_rd_access |-> prdata == rps_pkg::RDATA_ZERO;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_pready;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |-> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("wait state inserted");

  property p_mapped_ok;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && chk_hit |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");

  // only a bus write access may touch the selectors
  property p_idle_no_write;
    @(posedge pclk) disable iff (!presetn)
      !(psel && penable && pwrite) |-> !rif.wr_lo && !rif.wr_hi;
  endproperty
  a_idle_no_write: assert property (p_idle_no_write) else $error("stray write strobe");

  property p_sel_stable;
    @(posedge pclk) disable iff (!presetn)
      !rif.wr_lo && !rif.wr_hi |=> $stable(sel_reg);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("selector moved without write");

  property p_inactive_low;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |-> (remap_pin_out & ~remap_pin_active) == 14'h0000;
  endproperty
  a_inactive_low: assert property (p_inactive_low) else $error("unassigned pin driven high");

  property p_active_all;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> remap_pin_active == $past(exp_act);
  endproperty
  a_active_all: assert property (p_active_all) else $error("pin active flags wrong");

  // the absent pin 15 field reads zero in the small package
  property p_small_read;
    @(posedge pclk) disable iff (!presetn)
      (s_rd_setup and (SMALL_PKG && chk_idx == rps_pkg::SMALL_PAIR)) ##1 s_rd_access
        |-> prdata[13:8] == 6'h00;
  endproperty
  a_small_read: assert property (p_small_read) else $error("absent field reads non-zero");

  property p_reset_outputs;
    @(posedge pclk) $rose(presetn) |-> (remap_pin_active == 14'h0000) && (prdata == 32'h00000000);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not clear after reset");

  property p_lo_lane;
    @(posedge pclk) disable iff (!presetn)
      rif.wr_lo |-> psel && penable && pwrite && pstrb[0] && chk_hit;
  endproperty
  a_lo_lane: assert property (p_lo_lane) else $error("even write without low lane");

  property p_hi_lane;
    @(posedge pclk) disable iff (!presetn)
      rif.wr_hi |-> psel && penable && pwrite && pstrb[1] && chk_hit;
  endproperty
  a_hi_lane: assert property (p_hi_lane) else $error("odd write without high lane");

  property p_rsv_always;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |-> (prdata[15:14] == 2'b00) && (prdata[7:6] == 2'b00);
  endproperty
  a_rsv_always: assert property (p_rsv_always) else $error("reserved read bits set");
endmodule

// File: testbench/rps_periph_model.sv
// peripheral output model feeding the function lines
`timescale 1ns/1ps
module rps_periph_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic [63:0] periph_out
);
  // rotate and invert so every line keeps toggling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_out <= 64'h0123456789ABCDEF;
    end else begin
      periph_out <= ~{periph_out[62:0], periph_out[63]};
    end
  end
endmodule

// File: testbench/rps_top_test.sv
// self-checking bench for the remappable output pin select block
`timescale 1ns/1ps
module rps_top_test;
  logic pclk, presetn, psel, penable, pwrite, err, err_s;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, rd_s, prdata, prdata_s;
  logic [3:0] pstrb;
  logic pready, pready_s, pslverr, pslverr_s;
  logic [63:0] periph_out;
  logic [13:0] pin_out, pin_act, pin_out_s, pin_act_s;
  logic [13:0][5:0] pin_sel, pin_sel_s;
  logic [5:0] exp_sel [14];
  int num_errors, tests_run, cycles;

  // full package and small package side by side on one bus
  rps_top u_rps_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_out(periph_out), .remap_pin_out(pin_out),
    .remap_pin_active(pin_act), .pin_output_select(pin_sel));
  rps_top #(.SMALL_PKG(1'b1)) u_rps_top_small (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s), .periph_out(periph_out),
    .remap_pin_out(pin_out_s), .remap_pin_active(pin_act_s), .pin_output_select(pin_sel_s));
  rps_periph_model u_rps_periph_model (.pclk(pclk), .presetn(presetn), .periph_out(periph_out));

  // 40 mhz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("ERROR %0t run did not finish", $time);
      final_report();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t pins got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 || pready_s !== 1'b1) @(posedge pclk);
    rd = prdata;
    rd_s = prdata_s;
    err = pslverr;
    err_s = pslverr_s;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected register word of pair k
  function automatic logic [31:0] pair_word(input int k);
    return {18'h0, exp_sel[2 * k + 1], 2'b00, exp_sel[2 * k]};
  endfunction

  // read all pairs back, then watch the pins against the peripheral lines
  task automatic check_all(input logic small_hi_zero);
    logic [63:0] prev;
    logic [13:0] eo, ea;
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0, 4'hF); // byte address is four times the pair
      chk_word(rd, pair_word(k));
      chk_word(32'(err), 32'h0);
      chk_word(32'(err_s), 32'h0);
      chk_word(rd_s, pair_word(k) & ((k == 1 && small_hi_zero) ? 32'h3F : 32'hFFFF));
    end
    for (int p = 0; p < 14; p++) begin
      chk_word(32'(pin_sel[p]), 32'(exp_sel[p]));
    end
    chk_word(32'(pin_sel_s[3]), 32'h0);
    @(negedge pclk);
    prev = periph_out;
    repeat (4) begin
      @(negedge pclk);
      for (int p = 0; p < 14; p++) begin
        ea[p] = (exp_sel[p] != 6'h00);
        eo[p] = ea[p] & prev[exp_sel[p]];
      end
      chk_pins(pin_out, eo);
      chk_pins(pin_act, ea);
      chk_pins(pin_out_s, eo & 14'h3FF7);
      chk_pins(pin_act_s, ea & 14'h3FF7);
      prev = periph_out;
    end
  endtask

  task automatic test_reset_values();
    for (int p = 0; p < 14; p++) exp_sel[p] = 6'h00;
    check_all(1'b1);
  endtask

  task automatic test_unimplemented_bits();
    for (int k = 0; k < 7; k++) apb(1'b1, 12'(4 * k), 32'hFFFFFFFF, 4'hF);
    for (int p = 0; p < 14; p++) exp_sel[p] = 6'h3F;
    check_all(1'b1);
  endtask

  // distinct function per pin, then single-lane writes touch pins 17 and 20 only
  task automatic test_routing();
    for (int p = 0; p < 14; p++) exp_sel[p] = 6'(p * 4 + 3);
    for (int k = 0; k < 7; k++) apb(1'b1, 12'(4 * k), pair_word(k) | 32'hC0C0, 4'hF);
    check_all(1'b1);
    apb(1'b1, 12'h008, 32'h0, 4'h2);
    exp_sel[5] = 6'h00;
    apb(1'b1, 12'h010, 32'hFFFF, 4'h1);
    exp_sel[8] = 6'h3F;
    check_all(1'b1);
  endtask

  // unmapped place is refused and leaves the map alone
  task automatic test_unmapped();
    apb(1'b1, 12'h01C, 32'hFFFFFFFF, 4'hF);
    chk_word(32'(err), 32'h1);
    chk_word(32'(err_s), 32'h1);
    apb(1'b0, 12'h01C, 32'h0, 4'hF);
    chk_word(32'(err), 32'h1);
    chk_word(rd, 32'h0);
    chk_word(rd_s, 32'h0);
    check_all(1'b1);
  endtask

  // reset in mid-run clears every selector
  task automatic test_mid_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 14; p++) exp_sel[p] = 6'h00;
    check_all(1'b1);
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_values();
    test_unimplemented_bits();
    test_routing();
    test_unmapped();
    test_mid_reset();
    final_report();
  end
endmodule
